// >>> dv/pin_load.sv
// Load model that measures pulse width and period on one channel pin.
module pin_load (
  input wire clk_sys, // System clock.
  input wire pin, // Resolved pin level.
  output logic [15:0] high_len, // Last high time.
  output logic [15:0] period_len // Last rise to rise time.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rise_at = 16'h0000;
  logic [15:0] now = 16'h0000;
  logic last = 1'b0;
  // period and width
  // Edge to edge timing, so a missed compare shows up as a long pulse.
  always @(posedge clk_sys) begin
    now <= now + 16'h0001;
    last <= pin;
    if (pin && !last) begin
      rise_at <= now;
      period_len <= now - rise_at;
    end
    if (!pin && last) high_len <= now - rise_at;
  end
endmodule // pin_load

// >>> dv/timer_buffered_compare_pwm_tb.sv
// Self-checking bench of the buffered compare and PWM timer.
module timer_buffered_compare_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic ext_clk_pin = 1'b0;
  wire [15:0] rdata;
  wire [3:0] ch_pin_out;
  wire [3:0] ch_pin_oe;
  wire ovf_irq;
  wire [3:0] ch_irq;
  wire [15:0] hi0, per0, hi2, per2;
  // Undriven pins are pulled low.
  wire [3:0] pin_lvl = ch_pin_oe & ch_pin_out;
  wire [4:0] req = {ovf_irq, ch_irq};
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] d;
  int n;
  timer_buffered_compare_pwm dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .ext_clk_pin(ext_clk_pin), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
    .ovf_irq(ovf_irq), .ch_irq(ch_irq));
  pin_load u_load0 (.clk_sys(clk_sys), .pin(pin_lvl[0]), .high_len(hi0), .period_len(per0));
  pin_load u_load2 (.clk_sys(clk_sys), .pin(pin_lvl[2]), .high_len(hi2), .period_len(per2));
  // Clock at 25 MHz.
  initial forever #20 clk_sys = ~clk_sys;
  // Hang guard, about two and a half times the cycles the tests need.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus tasks start just after an edge and end one edge after the strobe drops,
  // so a following call never assigns the same strobe twice in one time step.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    // Read data stand in this cycle only, so they are taken at its closing edge.
    @(posedge clk_sys);
    d = rdata;
  endtask
  task automatic hold(input int ch, input logic lvl);
    n = 0;
    repeat (256) begin
      @(posedge clk_sys);
      if (pin_lvl[ch] !== lvl) n++;
    end
    chk("steady pin misses", 16'h0000, 16'(n));
  endtask
  task automatic wait_req(input int b);
    n = 0;
    while (req[b] !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk("request", 16'h0001, {15'h0000, req[b]});
  endtask
  task automatic t_reset();
    rd(8'h00);
    chk("timer control", 16'h0020, d);
    rd(8'h02);
    chk("period limit", 16'hffff, d);
    rd(8'h04);
    chk("channel control", 16'h0000, d);
    repeat (10) @(posedge clk_sys);
    rd(8'h01);
    chk("halted counter", 16'h0000, d);
  endtask
  task automatic t_bus();
    wr(8'h02, 16'h00ff);
    rd(8'h02);
    chk("limit back", 16'h00ff, d);
    rd(8'h0c);
    chk("unmapped", 16'h0000, d);
    rd(8'h03);
    chk("unmapped", 16'h0000, d);
    wr(8'h00, 16'h0030);
    rd(8'h00);
    chk("halt and reset", 16'h0020, d);
  endtask
  task automatic t_pwm();
    wr(8'h00, 16'h0030);
    wr(8'h02, 16'h00ff);
    wr(8'h05, 16'h0040);
    wr(8'h04, 16'h001a);
    wr(8'h00, 16'h0000);
    repeat (1024) @(posedge clk_sys);
    chk("period", 16'd256, per0);
    chk("clear pulse", 16'd64, hi0);
    wr(8'h04, 16'h001e);
    repeat (1024) @(posedge clk_sys);
    chk("set pulse", 16'd192, hi0);
    wr(8'h04, 16'h001a);
    wr(8'h05, 16'h0080);
    repeat (1024) @(posedge clk_sys);
    chk("half duty", 16'd128, hi0);
    wr(8'h04, 16'h0018);
    repeat (600) @(posedge clk_sys);
    hold(0, 1'b0);
    wr(8'h04, 16'h0019);
    repeat (600) @(posedge clk_sys);
    hold(0, 1'b1);
  endtask
  task automatic t_buf(input int p);
    wr(8'h00, 16'h0030);
    wr(8'(5 + 2 * p), 16'h0040);
    wr(8'(4 + 2 * p), 16'h003a);
    wr(8'(6 + 2 * p), 16'h007a);
    wr(8'h00, 16'h0000);
    repeat (1024) @(posedge clk_sys);
    chk("even governs", 16'd64, p == 0 ? hi0 : hi2);
    chk("buffered period", 16'd256, p == 0 ? per0 : per2);
    wr(8'(7 + 2 * p), 16'h00c0);
    repeat (1024) @(posedge clk_sys);
    chk("odd governs", 16'd192, p == 0 ? hi0 : hi2);
    wr(8'(5 + 2 * p), 16'h0020);
    repeat (1024) @(posedge clk_sys);
    chk("even again", 16'd32, p == 0 ? hi0 : hi2);
    chk("freed pin", 16'h0000, {14'h0000, ch_pin_oe[p + 1], ch_irq[p + 1]});
    rd(8'(6 + 2 * p));
    chk("odd control", 16'h0000, {10'h000, d[5], 5'h00});
  endtask
  task automatic t_irq();
    wr(8'h00, 16'h0030);
    wr(8'h02, 16'h000f);
    wr(8'h05, 16'h0005);
    wr(8'h04, 16'h005a);
    wr(8'h00, 16'h0040);
    wait_req(4);
    wait_req(0);
    wr(8'h00, 16'h0020);
    wr(8'h04, 16'h001a);
    // A rollover in the halting cycle keeps the flag, so clear it again while halted.
    wr(8'h00, 16'h0020);
    rd(8'h00);
    chk("flag cleared", 16'h0020, d);
    chk("requests off", 16'h0000, {11'h000, req});
    rd(8'h01);
    n = d;
    repeat (5) @(posedge clk_sys);
    rd(8'h01);
    chk("stopped count", 16'(n), d);
  endtask
  // Divided bus clock, then the synchronised count pin as the count source.
  task automatic t_prescale();
    wr(8'h00, 16'h0001);
    repeat (160) @(posedge clk_sys);
    chk("divided period", 16'd32, per0);
    chk("divided pulse", 16'd10, hi0);
    wr(8'h00, 16'h0007);
    repeat (120) begin
      repeat (2) @(posedge clk_sys);
      ext_clk_pin <= ~ext_clk_pin;
    end
    chk("pin clock period", 16'd64, per0);
    chk("pin clock pulse", 16'd20, hi0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_bus();
    t_pwm();
    t_buf(0);
    t_buf(2);
    t_irq();
    t_prescale();
    stop_test();
  end
endmodule // timer_buffered_compare_pwm_tb

// >>> dv/timer_pwm_monitor.sv
// Checker of the timer block port behaviour.
module timer_pwm_monitor (
  input wire clk_sys, // System clock.
  input wire rst_b, // Reset, active low.
  input wire [7:0] addr, // Register address.
  input wire [15:0] wdata, // Write data.
  input wire wr_stb, // Write strobe.
  input wire rd_stb, // Read strobe.
  input wire [15:0] rdata, // Read data.
  input wire [3:0] ch_pin_out, // Pin levels.
  input wire [3:0] ch_pin_oe, // Pin enables.
  input wire ovf_irq, // Overflow request.
  input wire [3:0] ch_irq // Channel requests.
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Read data are zero outside the cycle after a read.
  property p_rdata_idle;
    !rd_stb |=> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  // Unmapped places from 0x0c up read as zero.
  property p_unmapped;
    rd_stb && addr >= 8'h0c |=> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_limit_back;
    wr_stb && addr == 8'h02 ##2 rd_stb && addr == 8'h02 |=> rdata == $past(wdata, 3);
  endproperty
  a_limit_back: assert property (p_limit_back) else $error("limit read back wrong");
  // Odd channels have no upper mode bit.
  property p_odd_mode;
    rd_stb && (addr == 8'h06 || addr == 8'h0a) |=> rdata[5] == 1'b0;
  endproperty
  a_odd_mode: assert property (p_odd_mode) else $error("odd mode bit set");
  property p_free01;
    wr_stb && addr == 8'h04 && wdata[5] |=> !ch_pin_oe[1] && !ch_irq[1];
  endproperty
  a_free01: assert property (p_free01) else $error("channel 1 not freed");
  property p_free23;
    wr_stb && addr == 8'h08 && wdata[5] |=> !ch_pin_oe[3] && !ch_irq[3];
  endproperty
  a_free23: assert property (p_free23) else $error("channel 3 not freed");
  // A released pin keeps its level.
  property p_hold1;
    !ch_pin_oe[1] && !wr_stb |=> $stable(ch_pin_out[1]);
  endproperty
  a_hold1: assert property (p_hold1) else $error("freed pin moved");
  property p_ovf_gate;
    wr_stb && addr == 8'h00 && !wdata[6] |=> !ovf_irq;
  endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request ungated");
endmodule // timer_pwm_monitor

bind timer_buffered_compare_pwm timer_pwm_monitor mon_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
  .ovf_irq(ovf_irq), .ch_irq(ch_irq));

// >>> rtl/compare_channel.v
// Output compare and PWM pin logic of one timer channel.
`include "pwm_timer_consts.vh"
module compare_channel (
  input wire clk_sys, // System clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire enabled, // Channel drives its pin.
  input wire step, // Counter took a new value.
  input wire wrap, // Counter rolled over.
  input wire [`DW-1:0] count, // Counter value.
  input wire [`DW-1:0] compare_value, // Governing compare value.
  input wire [1:0] compare_action_field, // Action on compare.
  input wire toggle_at_wrap, // Toggle pin at rollover.
  input wire full_duty_select, // Force full duty while toggle_at_wrap is clear.
  output wire match, // Compare hit, one-cycle pulse.
  output reg pin_reg // Pin level.
);
  reg pin_next;

  assign match = step && (count == compare_value);

  // Compare is applied after the rollover toggle, so a zero width gives 0%.
  always @* begin
    pin_next = pin_reg;
    if (wrap && toggle_at_wrap) begin
      pin_next = ~pin_reg;
    end
    if (match) begin
      case (compare_action_field)
        `ELS_TOGGLE: pin_next = ~pin_next;
        `ELS_CLEAR: pin_next = 1'b0;
        `ELS_SET: pin_next = 1'b1;
        default: pin_next = pin_next;
      endcase
    end
    if (full_duty_select && !toggle_at_wrap) begin
      pin_next = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_reg <= 1'b0;
    end else if (enabled) begin
      pin_reg <= pin_next;
    end
  end
endmodule // compare_channel

// >>> rtl/pwm_timer_consts.vh
// Constants for the buffered compare and PWM timer block.
`ifndef PWM_TIMER_CONSTS_VH
`define PWM_TIMER_CONSTS_VH
// Bus widths.
`define AW 8
`define DW 16
// Register addresses of the plain register port, one address per register.
`define ADDR_TSC 8'h00
`define ADDR_CNT 8'h01
`define ADDR_MOD 8'h02
`define ADDR_CH_BASE 8'h04
`define ADDR_CH_STEP 8'h02
`define ADDR_CH_END 8'h0c
// Timer status and control field positions.
`define TSC_TOF 7
`define TSC_TOIE 6
`define TSC_HALT 5
`define TSC_TRST 4
`define TSC_PS_HI 2
`define TSC_PS_LO 0
// Channel status and control field positions.
`define CSC_FLAG 7
`define CSC_IE 6
`define CSC_MSB 5
`define CSC_MSA 4
`define CSC_ELS_HI 3
`define CSC_ELS_LO 2
`define CSC_TOV 1
`define CSC_MAX 0
// Compare action codes.
`define ELS_OFF 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
// Mode field codes, upper bit first.
`define MODE_UNBUF 2'h1
`define MODE_BUF 2'h2
// Prescaler select code for the external clock pin.
`define PS_EXT 3'h7
`define PRE_ALL 6'h3f
// Reset values.
`define MOD_RST 16'hffff
`define CNT_RST 16'h0000
`define CNT_ONE 16'h0001
`define CSC_RST 8'h00
`define VAL_RST 16'h0000
`endif

// >>> rtl/timer_buffered_compare_pwm.v
// Four-channel timer with buffered output compare and PWM.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`include "pwm_timer_consts.vh"
module timer_buffered_compare_pwm (
  input wire clk_sys, // System clock, 25 MHz.
  input wire rst_b, // Asynchronous reset, active low.
  input wire [`AW-1:0] addr, // Register address.
  input wire [`DW-1:0] wdata, // Register write data.
  input wire wr_stb, // Write strobe.
  input wire rd_stb, // Read strobe.
  output wire [`DW-1:0] rdata, // Read data, cycle after strobe.
  input wire ext_clk_pin, // External count clock pin.
  output wire [3:0] ch_pin_out, // Channel pin levels.
  output wire [3:0] ch_pin_oe, // Channel pin drive enables.
  output wire ovf_irq, // Overflow request level.
  output wire [3:0] ch_irq // Channel compare request levels.
);
  // Timer status and control state.
  reg tof_reg;
  reg toie_reg;
  reg counter_halt_reg;
  reg [2:0] ps_reg;
  reg [`DW-1:0] period_limit_reg;
  reg [`DW-1:0] rdata_reg;
  reg [`DW-1:0] rd_next;
  reg [2:0] rd_ch;

  // Flattened per-channel views for read-back and pair logic.
  wire [31:0] sc_bus;
  wire [63:0] val_bus;
  wire [1:0] linked;
  wire [1:0] sel_odd;
  wire [`DW-1:0] count;
  wire step;
  wire wrap;
  wire wr_tsc;
  wire trst;

  // Write to the timer status and control register.
  assign wr_tsc = wr_stb && (addr == `ADDR_TSC);

  // The reset bit is write-only and acts as a one-cycle pulse.
  assign trst = wr_tsc && wdata[`TSC_TRST];

  // Timer status and control. The overflow flag is cleared by writing zero,
  // but a rollover in the same cycle wins so that no overflow is lost.
  // halt set at reset
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tof_reg <= 1'b0;
      toie_reg <= 1'b0;
      counter_halt_reg <= 1'b1;
      ps_reg <= 3'h0;
    end else begin
      if (wrap) begin
        tof_reg <= 1'b1;
      end else if (wr_tsc && !wdata[`TSC_TOF]) begin
        tof_reg <= 1'b0;
      end
      if (wr_tsc) begin
        toie_reg <= wdata[`TSC_TOIE];
        counter_halt_reg <= wdata[`TSC_HALT];
        ps_reg <= wdata[`TSC_PS_HI:`TSC_PS_LO];
      end
    end
  end

  // Period limit; one word write replaces the whole value at once.
  // limit sets period
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      period_limit_reg <= `MOD_RST;
    end else if (wr_stb && (addr == `ADDR_MOD)) begin
      period_limit_reg <= wdata;
    end
  end

  // Shared prescaler and counter.
  timer_count u_count (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .counter_halt(counter_halt_reg),
    .trst(trst),
    .ps(ps_reg),
    .period_limit(period_limit_reg),
    .ext_clk_pin(ext_clk_pin),
    .count_reg(count),
    .step_reg(step),
    .wrap_reg(wrap)
  );

  assign ovf_irq = tof_reg & toie_reg;

  // One block per channel: control, compare value, flag; even channels also pair select.
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ch
      localparam EVEN = (i % 2) == 0;
      localparam P = i / 2;
      localparam PARTNER = EVEN ? i + 1 : i - 1;
      localparam integer SC_I = `ADDR_CH_BASE + `ADDR_CH_STEP * i;
      localparam integer PSC_I = `ADDR_CH_BASE + `ADDR_CH_STEP * PARTNER;
      localparam [`AW-1:0] SC_A = SC_I[`AW-1:0];
      localparam [`AW-1:0] VAL_A = SC_A + 8'h01;
      localparam [`AW-1:0] PVAL_A = PSC_I[`AW-1:0] + 8'h01;
      reg [7:0] sc_reg;
      reg [`DW-1:0] val_reg;
      wire wr_sc;
      wire wr_val;
      wire freed;
      wire buf_mode;
      wire drives;
      wire match;
      wire pin;
      wire [`DW-1:0] eff_val;
      wire [1:0] els;

      assign wr_sc = wr_stb && (addr == SC_A);
      assign wr_val = wr_stb && (addr == VAL_A);
      assign els = sc_reg[`CSC_ELS_HI:`CSC_ELS_LO];

      assign freed = !EVEN && linked[P];
      assign buf_mode = EVEN && sc_reg[`CSC_MSB];

      assign drives = !freed && (els != `ELS_OFF) &&
                      (buf_mode || sc_reg[`CSC_MSA]);

      assign eff_val = (buf_mode && sel_odd[P]) ? val_bus[16*PARTNER+:16] : val_reg;

      assign sc_bus[8*i+:8] = sc_reg;
      assign val_bus[16*i+:16] = val_reg;

      // Control and flag. Odd channels hold no upper mode bit; it reads zero.
      // A compare in the clearing cycle keeps the flag set.
      // compare flag set on match
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          sc_reg <= `CSC_RST;
        end else begin
          if (wr_sc) begin
            sc_reg[`CSC_IE] <= wdata[`CSC_IE];
            sc_reg[`CSC_MSB] <= EVEN ? wdata[`CSC_MSB] : 1'b0;
            sc_reg[`CSC_MSA] <= wdata[`CSC_MSA];
            sc_reg[`CSC_ELS_HI:`CSC_ELS_LO] <= wdata[`CSC_ELS_HI:`CSC_ELS_LO];
            sc_reg[`CSC_TOV] <= wdata[`CSC_TOV];
            sc_reg[`CSC_MAX] <= wdata[`CSC_MAX];
          end
          if (match && !freed) begin
            sc_reg[`CSC_FLAG] <= 1'b1;
          end else if (wr_sc && !wdata[`CSC_FLAG]) begin
            sc_reg[`CSC_FLAG] <= 1'b0;
          end
        end
      end

      // Compare value; unbuffered writes land at once and may be passed.
      // no write synchronisation
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          val_reg <= `VAL_RST;
        end else if (wr_val) begin
          val_reg <= wdata;
        end
      end

      // Pin logic of the channel.
      compare_channel u_cmp (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .enabled(drives),
        .step(step),
        .wrap(wrap),
        .count(count),
        .compare_value(eff_val),
        .compare_action_field(els),
        .toggle_at_wrap(sc_reg[`CSC_TOV]),
        .full_duty_select(sc_reg[`CSC_MAX]),
        .match(match),
        .pin_reg(pin)
      );

      // A freed odd pin is released for general use by dropping its enable.
      assign ch_pin_out[i] = pin;
      assign ch_pin_oe[i] = drives;
      assign ch_irq[i] = sc_reg[`CSC_FLAG] & sc_reg[`CSC_IE] & !freed;

      if (EVEN) begin : g_pair
        reg sel_reg;
        reg pend_reg;
        wire wr_partner;

        assign wr_partner = wr_stb && (addr == PVAL_A);
        assign linked[P] = sc_reg[`CSC_MSB];
        assign sel_odd[P] = sel_reg;

        // The half written last is remembered and takes over at the next
        // rollover, so a new width in the standby half never cuts into a running period.
        // Unlinking returns control to the even half.
        // standby takes next period
        always @(posedge clk_sys or negedge rst_b) begin
          if (!rst_b) begin
            sel_reg <= 1'b0;
            pend_reg <= 1'b0;
          end else if (!linked[P]) begin
            sel_reg <= 1'b0;
            pend_reg <= 1'b0;
          end else begin
            if (wr_partner) begin
              pend_reg <= 1'b1;
            end else if (wr_val) begin
              pend_reg <= 1'b0;
            end
            if (wrap) begin
              sel_reg <= pend_reg;
            end
          end
        end
      end
    end
  endgenerate

  // Read decode. Channel registers sit in pairs from the channel base.
  always @* begin
    rd_next = `CNT_RST;
    rd_ch = addr[3:1] - 3'h2;
    if (addr == `ADDR_TSC) begin
      rd_next[`TSC_TOF] = tof_reg;
      rd_next[`TSC_TOIE] = toie_reg;
      rd_next[`TSC_HALT] = counter_halt_reg;
      rd_next[`TSC_PS_HI:`TSC_PS_LO] = ps_reg;
    end else if (addr == `ADDR_CNT) begin
      rd_next = count;
    end else if (addr == `ADDR_MOD) begin
      rd_next = period_limit_reg;
    end else if ((addr >= `ADDR_CH_BASE) && (addr < `ADDR_CH_END)) begin
      if (addr[0]) begin
        rd_next = val_bus[16*rd_ch[1:0]+:16];
      end else begin
        rd_next[7:0] = sc_bus[8*rd_ch[1:0]+:8];
      end
    end
  end

  // Read data stands only in the cycle after the strobe; zero otherwise.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= `CNT_RST;
    end else if (rd_stb) begin
      rdata_reg <= rd_next;
    end else begin
      rdata_reg <= `CNT_RST;
    end
  end

  assign rdata = rdata_reg;
endmodule // timer_buffered_compare_pwm

// >>> rtl/timer_count.v
// Prescaler and 16-bit counter with wrap at the period limit.
`include "pwm_timer_consts.vh"
module timer_count (
  input wire clk_sys, // System clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire counter_halt, // Hold the counter.
  input wire trst, // Clear prescaler and counter, one-cycle pulse.
  input wire [2:0] ps, // Prescaler select.
  input wire [`DW-1:0] period_limit, // Period limit value.
  input wire ext_clk_pin, // External count clock pin.
  output reg [`DW-1:0] count_reg, // Counter value.
  output reg step_reg, // Counter took a new value this cycle.
  output reg wrap_reg // Counter rolled over to zero this cycle.
);
  reg [5:0] pre_reg;
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg ext_s3_reg;
  wire [5:0] mask;
  wire tick;

  // The pin crosses into this domain through two flops before the edge test.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clk_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // A divide by two to the ps ticks when the low ps prescaler bits are all ones.
  assign mask = ~(`PRE_ALL << ps);
  assign tick = (ps == `PS_EXT) ? (ext_s2_reg & ~ext_s3_reg) :
                (&(pre_reg | ~mask));

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= 6'h00;
      count_reg <= `CNT_RST;
      step_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end else if (trst) begin
      pre_reg <= 6'h00;
      count_reg <= `CNT_RST;
      step_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end else if (counter_halt) begin
      step_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 6'h01;
      step_reg <= tick;
      wrap_reg <= tick && (count_reg == period_limit);
      if (tick) begin
        count_reg <= (count_reg == period_limit) ? `CNT_RST : count_reg + `CNT_ONE;
      end
    end
  end
endmodule // timer_count
